//--- charger_status_alert_registers_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module charger_status_alert_registers_tb_top;
    import csa_pkg::*;
    localparam int SEC = 20;
    localparam int MEAS = 8;
    // {chemistry, suspend, equalize, absorb, ratio, precondition, fault, near, absent, shorted, bit}
    localparam logic [14:0] PH_TAB [12] = '{{2'h0, 9'h001, 4'h0}, {2'h0, 9'h002, 4'h1}, {2'h0, 9'h004, 4'h8},
        {2'h0, 9'h008, 4'h8}, {2'h0, 9'h100, 4'h8}, {2'h0, 9'h010, 4'h7}, {2'h0, 9'h020, 4'h5},
        {2'h2, 9'h080, 4'hA}, {2'h2, 9'h040, 4'h9}, {2'h1, 9'h040, 4'h9}, {2'h0, 9'h003, 4'h0}, {2'h0, 9'h000, 4'h6}};
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] chemistry;
    logic [8:0] cond;
    logic programmable_config, charge_request, current_below_taper, meas_system_on, ack_en;
    logic reg_wr, reg_rd, reg_rvalid, alert_response_done, smbalert_out, smbalert_oe_n;
    logic fractional_stop_active, thermal_adjust_active, zone_profile_active;
    logic [7:0] reg_addr, ack_delay;
    logic [3:0] loop_in_control;
    logic [15:0] reg_wdata, reg_rdata, voltage_hold_limit, overall_charge_limit;
    logic [15:0] excursion_conditions, threshold_flag_enables;
    logic [15:0] exp_q[$];
    logic [31:0] seed = 32'h5840fcee;
    int num_errors = 0;
    int check_count = 0;
    always #10 clk_sys = ~clk_sys;
    csa_charger_status_alert_registers #(.SECOND_COUNT(SEC), .MEAS_COUNT(MEAS), .WARMUP_COUNT(30)) i_dut (
        .clk_sys, .resetn, .chemistry, .programmable_config, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid, .charge_request, .request_suspend(cond[8]), .input_near_battery(cond[2]),
        .system_fault(cond[3]), .battery_shorted(cond[0]), .battery_absent(cond[1]),
        .battery_below_precondition(cond[4]), .current_below_taper, .ratio_outside_zones(cond[5]),
        .absorb_request(cond[6]), .equalize_request(cond[7]), .voltage_hold_limit, .overall_charge_limit,
        .loop_in_control, .meas_system_on, .excursion_conditions, .threshold_flag_enables, .alert_response_done,
        .smbalert_out, .smbalert_oe_n, .fractional_stop_active, .thermal_adjust_active, .zone_profile_active);
    csa_host_model i_host (.clk_sys, .smbalert_oe_n, .ack_en, .ack_delay, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .alert_response_done);
    // ----
    // Helpers
    // ----
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        i_host.xfer(1'b0, a, 16'h0000);
        @(negedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_host.xfer(1'b1, a, d);
    endtask
    always @(negedge clk_sys) begin
        if (reg_rvalid === 1'b1 && exp_q.size() > 0) check("reg_rdata", reg_rdata, exp_q.pop_front());
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        complete_run();
    end
    // ----
    // Scenarios
    // ----
    initial begin
        chemistry = CHEM_LITHIUM_ION;
        {programmable_config, charge_request, current_below_taper, ack_en, cond} = 13'h0000;
        meas_system_on = 1'b1;
        ack_delay = 8'h01;
        voltage_hold_limit = 16'hFFFF;
        overall_charge_limit = 16'hFFFF;
        loop_in_control = 4'h0;
        excursion_conditions = 16'h0000;
        threshold_flag_enables = 16'h0000;
        cyc(5);
        resetn = 1'b1;
        cyc(2);
        rd(ADDR_FEATURE_ENABLES, 16'h0003);
        check("zone_profile_active", 16'(zone_profile_active), 16'h0001);
        wr(ADDR_FEATURE_ENABLES, 16'hFFF8);
        rd(ADDR_FEATURE_ENABLES, 16'h0003);
        programmable_config = 1'b1;
        for (int i = 0; i < 4; i++) begin
            seed = xorshift(seed);
            wr(ADDR_FEATURE_ENABLES, seed[15:0]);
            rd(ADDR_FEATURE_ENABLES, {13'h0000, seed[2:0]});
            check("fractional_stop_active", 16'(fractional_stop_active), 16'(seed[2]));
            check("zone_profile_active", 16'(zone_profile_active), 16'(seed[0]));
        end
        chemistry = CHEM_LEAD_ACID;
        wr(ADDR_FEATURE_ENABLES, 16'h0007);
        cyc(2);
        check("features", {13'h0000, fractional_stop_active, thermal_adjust_active, zone_profile_active},
            16'h0002);
        charge_request = 1'b1;
        seed = xorshift(seed);
        wr(ADDR_EQUALIZE_SECONDS, seed[15:0]);
        rd(ADDR_EQUALIZE_SECONDS, seed[15:0]);
        rd(8'h40, 16'h0000);
        foreach (PH_TAB[i]) begin
            {chemistry, cond} = PH_TAB[i][14:4];
            cyc(3);
            rd(ADDR_PHASE_INDICATORS, 16'h0001 << PH_TAB[i][3:0]);
        end
        for (int i = 0; i < 6; i++) begin
            seed = xorshift(seed);
            loop_in_control = seed[3:0];
            cyc(2);
            rd(ADDR_LOOP_STATUS, {12'h000, seed[3], seed[3:2] == 2'h1, seed[3:1] == 3'h1,
                seed[3:0] == 4'h1});
        end
        loop_in_control = 4'h1;
        wr(ADDR_FEATURE_ENABLES, 16'h0003);
        cyc(1);
        current_below_taper = 1'b1;
        cyc(3);
        rd(ADDR_PHASE_INDICATORS, 16'h0040);
        wr(ADDR_FEATURE_ENABLES, 16'h0007);
        cyc(3);
        rd(ADDR_PHASE_INDICATORS, 16'h0008);
        {charge_request, current_below_taper} = 2'h0;
        voltage_hold_limit = 16'h0003;
        cyc(2);
        charge_request = 1'b1;
        cyc(5 * SEC);
        rd(ADDR_PHASE_INDICATORS, 16'h0010);
        rd(ADDR_HOLD_SECONDS, 16'h0003);
        rd(ADDR_ABSORB_SECONDS, 16'h0000);
        charge_request = 1'b0;
        voltage_hold_limit = 16'hFFFF;
        overall_charge_limit = 16'h0002;
        cyc(2);
        charge_request = 1'b1;
        cyc(6 * SEC);
        rd(ADDR_PHASE_INDICATORS, 16'h0004);
        rd(ADDR_TOTAL_SECONDS, 16'h0003);
        charge_request = 1'b0;
        excursion_conditions = 16'h6800;
        threshold_flag_enables = 16'hFC00;
        cyc(2 * MEAS + 4);
        rd(ADDR_THRESHOLD_FLAGS, 16'hA800);
        check("smbalert_oe_n", 16'(smbalert_oe_n), 16'h0000);
        ack_en = 1'b1;
        cyc(6);
        check("smbalert_oe_n", 16'(smbalert_oe_n), 16'h0001);
        excursion_conditions = 16'h6000;
        // Let a measurement cycle end so the dropped condition is seen
        cyc(MEAS);
        wr(ADDR_THRESHOLD_FLAGS, 16'hF7FF);
        rd(ADDR_THRESHOLD_FLAGS, 16'hA000);
        ack_en = 1'b0;
        wr(ADDR_THRESHOLD_FLAGS, 16'hDFFF);
        cyc(4);
        check("smbalert_oe_n", 16'(smbalert_oe_n), 16'h0000);
        rd(ADDR_THRESHOLD_FLAGS, 16'hA000);
        ack_delay = 8'h28;
        ack_en = 1'b1;
        cyc(20);
        check("smbalert_oe_n", 16'(smbalert_oe_n), 16'h0000);
        cyc(30);
        check("smbalert_oe_n", 16'(smbalert_oe_n), 16'h0001);
        threshold_flag_enables = 16'h8000;
        cyc(2);
        rd(ADDR_THRESHOLD_FLAGS, 16'h8000);
        complete_run();
    end
endmodule
`default_nettype wire

//--- csa_charger_status_alert_registers.sv
`timescale 1ns/10ps
`default_nettype none

module csa_charger_status_alert_registers
    import csa_pkg::*;
#(
    parameter int SECOND_COUNT = csa_pkg::SECOND_CYCLES,
    parameter int MEAS_COUNT = csa_pkg::MEAS_CYCLE_CYCLES,
    parameter int WARMUP_COUNT = csa_pkg::WARMUP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [1:0] chemistry,
    input wire logic programmable_config,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [csa_pkg::DATA_W-1:0] reg_wdata,
    output logic [csa_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic charge_request,
    input wire logic request_suspend,
    input wire logic input_near_battery,
    input wire logic system_fault,
    input wire logic battery_shorted,
    input wire logic battery_absent,
    input wire logic battery_below_precondition,
    input wire logic current_below_taper,
    input wire logic ratio_outside_zones,
    input wire logic absorb_request,
    input wire logic equalize_request,
    input wire logic [15:0] voltage_hold_limit,
    input wire logic [15:0] overall_charge_limit,
    input wire logic [csa_pkg::LOOP_W-1:0] loop_in_control,
    input wire logic meas_system_on,
    input wire logic [csa_pkg::FLAG_W-1:0] excursion_conditions,
    input wire logic [csa_pkg::FLAG_W-1:0] threshold_flag_enables,
    input wire logic alert_response_done,
    output logic smbalert_out,
    output logic smbalert_oe_n,
    output logic fractional_stop_active,
    output logic thermal_adjust_active,
    output logic zone_profile_active
);
    import csa_pkg::*;

    // ----
    // Declarations
    // ----
    logic [FEAT_W-1:0] feature_enables_reg;
    logic [15:0] total_seconds_reg;
    logic [SHORT_TIMER_W-1:0] hold_seconds_reg;
    logic [SHORT_TIMER_W-1:0] absorb_seconds_reg;
    logic [15:0] equalize_seconds_reg;
    logic [PHASE_W-1:0] phase_reg;
    logic [PHASE_W-1:0] phase_next;
    logic [LOOP_W-1:0] loop_reg;
    logic [LOOP_W-1:0] loop_next;
    logic [FLAG_W-1:0] flags_reg;
    logic [FLAG_W-1:0] flags_next;
    logic [FLAG_W-1:0] excursion_reg;
    logic [31:0] second_cnt_reg;
    logic [31:0] meas_cnt_reg;
    logic [31:0] warmup_cnt_reg;
    logic meas_ready_reg;
    logic second_tick;
    logic meas_end;
    logic stop_latched_reg;
    logic alert_pending_reg;
    logic is_lithium;
    logic is_li_ion;
    logic is_lead_acid;
    logic wr_flags;
    logic [FLAG_W-1:0] clear_mask;
    logic [FLAG_W-1:0] sources;
    logic charging;

    assign is_li_ion = (chemistry == CHEM_LITHIUM_ION);
    assign is_lead_acid = (chemistry == CHEM_LEAD_ACID);
    assign is_lithium = !is_lead_acid;
    assign second_tick = (second_cnt_reg == 32'(SECOND_COUNT - 1));
    assign meas_end = (meas_cnt_reg == 32'(MEAS_COUNT - 1));

    // ----
    // Time bases
    // ----
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            second_cnt_reg <= 32'h0;
        end else if (second_tick) begin
            second_cnt_reg <= 32'h0;
        end else begin
            second_cnt_reg <= second_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meas_cnt_reg <= 32'h0;
        end else if (meas_end) begin
            meas_cnt_reg <= 32'h0;
        end else begin
            meas_cnt_reg <= meas_cnt_reg + 32'h1;
        end
    end

    // Warm-up restarts whenever the measurement system is switched off
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            warmup_cnt_reg <= 32'h0;
            meas_ready_reg <= 1'b0;
        end else if (!meas_system_on) begin
            warmup_cnt_reg <= 32'h0;
            meas_ready_reg <= 1'b0;
        end else if (warmup_cnt_reg == 32'(WARMUP_COUNT - 1)) begin
            meas_ready_reg <= 1'b1;
        end else begin
            warmup_cnt_reg <= warmup_cnt_reg + 32'h1;
        end
    end

    // ----
    // Feature enables
    // ----
    // Writable only in programmable configuration; upper bits dropped
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            feature_enables_reg <= FEAT_RESET;
        end else if (reg_wr && programmable_config && reg_addr == ADDR_FEATURE_ENABLES) begin
            feature_enables_reg <= reg_wdata[FEAT_W-1:0];
        end
    end

    // Each enable only counts for its own chemistry
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fractional_stop_active <= 1'b0;
            thermal_adjust_active <= 1'b0;
            zone_profile_active <= 1'b0;
        end else begin
            fractional_stop_active <= is_lithium && feature_enables_reg[FEAT_FRACTIONAL_STOP];
            thermal_adjust_active <= is_lead_acid && feature_enables_reg[FEAT_THERMAL_ADJUST];
            zone_profile_active <= is_lithium && feature_enables_reg[FEAT_ZONE_PROFILE];
        end
    end

    // ----
    // Regulation loop
    // ----
    // Priority pick keeps the word one-hot even on overlapping inputs
    always_comb begin
        loop_next = '0;
        if (loop_in_control[LOOP_INPUT_SAG]) begin
            loop_next[LOOP_INPUT_SAG] = 1'b1;
        end else if (loop_in_control[LOOP_INPUT_CURRENT]) begin
            loop_next[LOOP_INPUT_CURRENT] = 1'b1;
        end else if (loop_in_control[LOOP_CURRENT]) begin
            loop_next[LOOP_CURRENT] = 1'b1;
        end else if (loop_in_control[LOOP_VOLTAGE]) begin
            loop_next[LOOP_VOLTAGE] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            loop_reg <= '0;
        end else begin
            loop_reg <= loop_next;
        end
    end

    // ----
    // Charger phase
    // ----
    always_comb begin
        phase_next = '0;
        if (!charge_request) begin
            phase_next = '0;
        end else if (stop_latched_reg) begin
            phase_next = phase_reg;
        end else if (battery_shorted) begin
            phase_next[PH_SHORTED_BATTERY] = 1'b1;
        end else if (battery_absent) begin
            phase_next[PH_ABSENT_BATTERY] = 1'b1;
        end else if (input_near_battery || request_suspend || system_fault) begin
            phase_next[PH_SUSPEND] = 1'b1;
        end else if (is_lithium && total_seconds_reg > overall_charge_limit) begin
            phase_next[PH_OVERTIME] = 1'b1;
        end else if (is_lithium && {5'h0, hold_seconds_reg} >= voltage_hold_limit
                     && phase_reg[PH_MAIN] && loop_reg[LOOP_VOLTAGE]) begin
            phase_next[PH_TIME_STOP] = 1'b1;
        end else if (fractional_stop_active && current_below_taper && loop_reg[LOOP_VOLTAGE]
                     && phase_reg[PH_MAIN]) begin
            phase_next[PH_TAPER_STOP] = 1'b1;
        end else if (zone_profile_active && ratio_outside_zones) begin
            phase_next[PH_THERMAL_PAUSE] = 1'b1;
        end else if (is_li_ion && battery_below_precondition) begin
            phase_next[PH_PRECONDITION] = 1'b1;
        end else if (is_lead_acid && equalize_request) begin
            phase_next[PH_EQUALIZE] = 1'b1;
        end else if (!is_li_ion && absorb_request) begin
            phase_next[PH_ABSORB] = 1'b1;
        end else begin
            phase_next[PH_MAIN] = 1'b1;
        end
    end

    // At most one bit set by construction: no request clears all bits, a latched stop holds, every other branch sets a single bit
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            phase_reg <= '0;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // Terminations hold until the charge request drops
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stop_latched_reg <= 1'b0;
        end else if (!charge_request) begin
            stop_latched_reg <= 1'b0;
        end else if (phase_next[PH_TIME_STOP] || phase_next[PH_TAPER_STOP] || phase_next[PH_OVERTIME]) begin
            stop_latched_reg <= 1'b1;
        end
    end

    assign charging = phase_reg[PH_MAIN] || phase_reg[PH_PRECONDITION]
                      || phase_reg[PH_ABSORB] || phase_reg[PH_EQUALIZE];

    // ----
    // Seconds counters
    // ----
    // Counters saturate rather than wrap so a limit compare stays true
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            total_seconds_reg <= 16'h0;
        end else if (!charge_request || !is_lithium) begin
            total_seconds_reg <= 16'h0;
        end else if (second_tick && charging && total_seconds_reg != 16'hFFFF) begin
            total_seconds_reg <= total_seconds_reg + 16'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hold_seconds_reg <= '0;
        end else if (!charge_request || !is_lithium) begin
            hold_seconds_reg <= '0;
        end else if (second_tick && phase_reg[PH_MAIN] && loop_reg[LOOP_VOLTAGE]
                     && hold_seconds_reg != {SHORT_TIMER_W{1'b1}}) begin
            hold_seconds_reg <= hold_seconds_reg + 11'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            absorb_seconds_reg <= '0;
        end else if (!charge_request || is_li_ion) begin
            absorb_seconds_reg <= '0;
        end else if (second_tick && phase_reg[PH_ABSORB]
                     && absorb_seconds_reg != {SHORT_TIMER_W{1'b1}}) begin
            absorb_seconds_reg <= absorb_seconds_reg + 11'h1;
        end
    end

    // Host write takes priority over the tick in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            equalize_seconds_reg <= 16'h0;
        end else if (reg_wr && programmable_config && reg_addr == ADDR_EQUALIZE_SECONDS) begin
            equalize_seconds_reg <= reg_wdata;
        end else if (!is_lead_acid) begin
            equalize_seconds_reg <= 16'h0;
        end else if (second_tick && phase_reg[PH_EQUALIZE] && equalize_seconds_reg != 16'hFFFF) begin
            equalize_seconds_reg <= equalize_seconds_reg + 16'h1;
        end
    end

    // ----
    // Threshold-crossing flags
    // ----
    assign sources = {meas_ready_reg, excursion_conditions[14:0]} & FLAG_IMPLEMENTED_MASK;
    assign wr_flags = reg_wr && reg_addr == ADDR_THRESHOLD_FLAGS;
    assign clear_mask = wr_flags ? ~reg_wdata : '0;

    // Excursions are sampled only at the end of a measurement cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            excursion_reg <= '0;
        end else if (meas_end) begin
            excursion_reg <= sources;
        end
    end

    // A clear with the condition still standing sets the bit again
    always_comb begin
        flags_next = flags_reg & ~clear_mask;
        flags_next = flags_next | (excursion_reg & clear_mask);
        if (meas_end) begin
            flags_next = flags_next | sources;
        end
        flags_next = flags_next & threshold_flag_enables & FLAG_IMPLEMENTED_MASK;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ----
    // Alert line
    // ----
    // A fresh alert beats a response finishing in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            alert_pending_reg <= 1'b0;
        end else if (|(flags_next & ~(flags_reg & ~clear_mask))) begin
            alert_pending_reg <= 1'b1;
        end else if (alert_response_done) begin
            alert_pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            smbalert_out <= 1'b0;
            smbalert_oe_n <= 1'b1;
        end else begin
            smbalert_out <= 1'b0;
            smbalert_oe_n <= !alert_pending_reg;
        end
    end

    // ----
    // Read port
    // ----
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                unique case (reg_addr)
                    ADDR_FEATURE_ENABLES: reg_rdata <= {13'h0, feature_enables_reg};
                    ADDR_TOTAL_SECONDS: reg_rdata <= total_seconds_reg;
                    ADDR_HOLD_SECONDS: reg_rdata <= {5'h0, hold_seconds_reg};
                    ADDR_ABSORB_SECONDS: reg_rdata <= {5'h0, absorb_seconds_reg};
                    ADDR_EQUALIZE_SECONDS: reg_rdata <= equalize_seconds_reg;
                    ADDR_PHASE_INDICATORS: reg_rdata <= {5'h0, phase_reg};
                    ADDR_LOOP_STATUS: reg_rdata <= {12'h0, loop_reg};
                    ADDR_THRESHOLD_FLAGS: reg_rdata <= flags_reg;
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

//--- csa_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module csa_host_model (
    input wire logic clk_sys,
    input wire logic smbalert_oe_n,
    input wire logic ack_en,
    input wire logic [7:0] ack_delay,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic alert_response_done
);
    int wait_cnt = 0;
    initial begin
        {reg_wr, reg_rd, alert_response_done} = 3'h0;
        reg_addr = 8'hFF;
        reg_wdata = 16'h0000;
    end
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // Idle bus shows inverted values so stale data never looks valid
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // Alert response after a chosen delay, once per pulled-low period
    always @(negedge clk_sys) begin
        alert_response_done <= 1'b0;
        if (ack_en && smbalert_oe_n === 1'b0) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt == int'(ack_delay)) alert_response_done <= 1'b1;
        end else begin
            wait_cnt <= 0;
        end
    end
endmodule
`default_nettype wire

//--- csa_pkg.sv
package csa_pkg;

    // ----
    // Register sub-addresses
    // ----
    localparam logic [7:0] ADDR_FEATURE_ENABLES = 8'h29;
    localparam logic [7:0] ADDR_TOTAL_SECONDS = 8'h30;
    localparam logic [7:0] ADDR_HOLD_SECONDS = 8'h31;
    localparam logic [7:0] ADDR_ABSORB_SECONDS = 8'h32;
    localparam logic [7:0] ADDR_EQUALIZE_SECONDS = 8'h33;
    localparam logic [7:0] ADDR_PHASE_INDICATORS = 8'h34;
    localparam logic [7:0] ADDR_LOOP_STATUS = 8'h35;
    localparam logic [7:0] ADDR_THRESHOLD_FLAGS = 8'h36;

    // ----
    // Widths
    // ----
    localparam int DATA_W = 16;
    localparam int FEAT_W = 3;
    localparam int SHORT_TIMER_W = 11;
    localparam int PHASE_W = 11;
    localparam int LOOP_W = 4;
    localparam int FLAG_W = 16;

    // ----
    // Field positions
    // ----
    localparam int FEAT_FRACTIONAL_STOP = 2;
    localparam int FEAT_THERMAL_ADJUST = 1;
    localparam int FEAT_ZONE_PROFILE = 0;

    localparam int PH_EQUALIZE = 10;
    localparam int PH_ABSORB = 9;
    localparam int PH_SUSPEND = 8;
    localparam int PH_PRECONDITION = 7;
    localparam int PH_MAIN = 6;
    localparam int PH_THERMAL_PAUSE = 5;
    localparam int PH_TIME_STOP = 4;
    localparam int PH_TAPER_STOP = 3;
    localparam int PH_OVERTIME = 2;
    localparam int PH_ABSENT_BATTERY = 1;
    localparam int PH_SHORTED_BATTERY = 0;

    localparam int LOOP_INPUT_SAG = 3;
    localparam int LOOP_INPUT_CURRENT = 2;
    localparam int LOOP_CURRENT = 1;
    localparam int LOOP_VOLTAGE = 0;

    localparam int FLAG_MEAS_READY = 15;
    localparam int FLAG_CHARGE_COUNT_LOW = 13;
    localparam int FLAG_CHARGE_COUNT_HIGH = 12;
    localparam int FLAG_BATTERY_VOLTAGE_LOW = 11;
    localparam int FLAG_BATTERY_VOLTAGE_HIGH = 10;
    // Bit 14 has no source
    localparam logic [15:0] FLAG_IMPLEMENTED_MASK = 16'hBFFF;

    // ----
    // Reset values
    // ----
    localparam logic [2:0] FEAT_RESET = 3'h3;

    // ----
    // Timing
    // ----
    localparam int CLK_HZ = 50000000;
    localparam int SECOND_US = 1000000;
    localparam int MEAS_CYCLE_US = 6500;
    localparam int WARMUP_US = 12000;
    localparam int SECOND_CYCLES = SECOND_US * (CLK_HZ / 1000000);
    localparam int MEAS_CYCLE_CYCLES = MEAS_CYCLE_US * (CLK_HZ / 1000000);
    localparam int WARMUP_CYCLES = WARMUP_US * (CLK_HZ / 1000000);

    // ----
    // Types
    // ----
    typedef enum logic [1:0] {
        CHEM_LITHIUM_ION,
        CHEM_IRON_PHOSPHATE,
        CHEM_LEAD_ACID
    } csa_chem_t;

endpackage

//--- csa_regs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module csa_regs_monitor
    import csa_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [1:0] chemistry,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [csa_pkg::DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [csa_pkg::FLAG_W-1:0] threshold_flag_enables,
    input wire logic alert_response_done,
    input wire logic smbalert_out,
    input wire logic smbalert_oe_n,
    input wire logic fractional_stop_active,
    input wire logic thermal_adjust_active,
    input wire logic zone_profile_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ----
    // Read answer of one sub-address
    // ----
    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a ##1 reg_rvalid;
    endsequence
    property p_phase_onehot;
        s_rd(ADDR_PHASE_INDICATORS) |-> reg_rdata[15:11] == 5'h00 && $onehot0(reg_rdata[10:0]);
    endproperty
    a_phase_onehot: assert property (p_phase_onehot) else $error("phase word not one-hot");
    property p_loop_onehot;
        s_rd(ADDR_LOOP_STATUS) |-> reg_rdata[15:4] == 12'h000 && $onehot0(reg_rdata[3:0]);
    endproperty
    a_loop_onehot: assert property (p_loop_onehot) else $error("loop word not one-hot");
    property p_hold_width;
        s_rd(ADDR_HOLD_SECONDS) |-> reg_rdata[15:11] == 5'h00;
    endproperty
    a_hold_width: assert property (p_hold_width) else $error("hold seconds too wide");
    // Enables may change near the read, so any recent enable admits a flag
    property p_flags_gated;
        s_rd(ADDR_THRESHOLD_FLAGS) |-> reg_rdata[14] == 1'b0 && (reg_rdata & ~(threshold_flag_enables
            | $past(threshold_flag_enables) | $past(threshold_flag_enables, 2))) == 16'h0000;
    endproperty
    a_flags_gated: assert property (p_flags_gated) else $error("flag set without enable");
    property p_alert_hold;
        !smbalert_oe_n && !alert_response_done && !$past(alert_response_done)
            && !$past(alert_response_done, 2) |=> !smbalert_oe_n && !smbalert_out;
    endproperty
    a_alert_hold: assert property (p_alert_hold) else $error("alert released early");
    property p_alert_cause;
        $fell(smbalert_oe_n) |-> $past(threshold_flag_enables, 2) != 16'h0000
            || $past(threshold_flag_enables, 3) != 16'h0000;
    endproperty
    a_alert_cause: assert property (p_alert_cause) else $error("alert without enabled flag");
    property p_lead_gate;
        chemistry == 2'h2 && $stable(chemistry) |-> !fractional_stop_active && !zone_profile_active;
    endproperty
    a_lead_gate: assert property (p_lead_gate) else $error("lithium feature active on lead-acid");
    property p_li_gate;
        chemistry != 2'h2 && $stable(chemistry) |-> !thermal_adjust_active;
    endproperty
    a_li_gate: assert property (p_li_gate) else $error("thermal adjust active on lithium");
endmodule
bind csa_charger_status_alert_registers csa_regs_monitor i_mon (.clk_sys, .resetn, .chemistry, .reg_rd,
    .reg_addr, .reg_rdata, .reg_rvalid, .threshold_flag_enables, .alert_response_done, .smbalert_out,
    .smbalert_oe_n, .fractional_stop_active, .thermal_adjust_active, .zone_profile_active);
`default_nettype wire
